// [rtl/knkspi_top.sv]
`timescale 1ns/10ps
`include "knkspi_map.svh"
module knkspi_top (
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_cs_n,
   input  wire logic                 i_sck,
   input  wire logic                 i_si,
   input  wire logic                 i_int_hold,
   input  wire logic                 i_test_n,
   input  wire knkspi_pkg::knkspi_word_t i_integrator_level,
   output logic                      o_so,
   output logic                      o_so_oe_n,
   output logic                      o_channel,
   output logic                      o_integrate,
   output knkspi_pkg::knkspi_word_t  o_integrator_buffered_output,
   output knkspi_pkg::knkspi_word_t  o_param_word
);
   import knkspi_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0]    cs_sync_q;
   logic [1:0]    sck_sync_q;
   logic [1:0]    si_sync_q;
   logic [1:0]    ih_sync_q;
   logic [1:0]    test_sync_q;
   logic          cs_prev_q;
   logic          sck_prev_q;
   logic          cs_s;
   logic          sck_s;
   logic          si_s;
   logic          ih_s;
   logic          test_n_s;
   logic          sck_fall;
   logic          cs_rise;

   // Reset values mimic the pad pulls so a floating pin reads its rest level
   // rests in hold
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_sync_q   <= `KNKSPI_SYNC_HIGH;
         sck_sync_q  <= `KNKSPI_SYNC_LOW;
         si_sync_q   <= `KNKSPI_SYNC_HIGH;
         ih_sync_q   <= `KNKSPI_SYNC_LOW;
         test_sync_q <= `KNKSPI_SYNC_HIGH;
      end else begin
         cs_sync_q   <= {cs_sync_q[0], i_cs_n};
         sck_sync_q  <= {sck_sync_q[0], i_sck};
         si_sync_q   <= {si_sync_q[0], i_si};
         ih_sync_q   <= {ih_sync_q[0], i_int_hold};
         test_sync_q <= {test_sync_q[0], i_test_n};
      end
   end

   assign cs_s     = cs_sync_q[1];
   assign sck_s    = sck_sync_q[1];
   assign si_s     = si_sync_q[1];
   assign ih_s     = ih_sync_q[1];
   assign test_n_s = test_sync_q[1];

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_prev_q  <= 1'h1;
         sck_prev_q <= 1'h0;
      end else begin
         cs_prev_q  <= cs_s;
         sck_prev_q <= sck_s;
      end
   end

   assign sck_fall = sck_prev_q & ~sck_s;
   assign cs_rise  = cs_s & ~cs_prev_q;

   // ------------------------------------------------------------
   // Word framing
   // ------------------------------------------------------------
   knkspi_state_e state_q;
   logic [3:0]    cnt_q;
   knkspi_word_t  shift_q;
   logic          commit;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= KNKSPI_IDLE;
         cnt_q   <= `KNKSPI_CNT_ZERO;
      end else if (cs_s) begin
         state_q <= KNKSPI_IDLE;
         cnt_q   <= `KNKSPI_CNT_ZERO;
      end else begin
         case (state_q)
            KNKSPI_IDLE: begin
               state_q <= KNKSPI_SHIFT;
            end
            KNKSPI_SHIFT: begin
               if (sck_fall) begin
                  cnt_q <= cnt_q + `KNKSPI_CNT_ONE;
                  if (cnt_q == `KNKSPI_WORD_BITS - `KNKSPI_CNT_ONE) begin
                     state_q <= KNKSPI_FULL;
                  end
               end
            end
            KNKSPI_FULL: begin
               // A ninth edge spoils the word rather than wrapping it
               if (sck_fall) begin
                  state_q <= KNKSPI_OVER;
               end
            end
            KNKSPI_OVER: begin
               state_q <= KNKSPI_OVER;
            end
            default: begin
               state_q <= KNKSPI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_q <= `KNKSPI_RST_WORD;
      end else if (!cs_s && sck_fall) begin
         shift_q <= {shift_q[`KNKSPI_MSB-1:0], si_s};
      end
   end

   assign commit = cs_rise && (state_q == KNKSPI_FULL);

   // ------------------------------------------------------------
   // Control settings
   // ------------------------------------------------------------
   logic          so_dis_q;
   logic [1:0]    word_class;

   assign word_class = shift_q[`KNKSPI_CLASS_HI:`KNKSPI_CLASS_LO];

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         so_dis_q     <= `KNKSPI_RST_SO_DIS;
         o_channel    <= `KNKSPI_RST_CHANNEL;
         o_param_word <= `KNKSPI_RST_WORD;
      end else if (commit) begin
         o_param_word <= shift_q;
         if (word_class == `KNKSPI_CLASS_PRESCALE) begin
            so_dis_q <= shift_q[`KNKSPI_CTRL_BIT];
         end
         if (word_class == `KNKSPI_CLASS_CHANNEL) begin
            o_channel <= shift_q[`KNKSPI_CTRL_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Serial output
   // ------------------------------------------------------------
   // Echoes the shift register so the master can read back the last word
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_so      <= 1'h0;
         o_so_oe_n <= 1'h1;
      end else begin
         o_so <= shift_q[`KNKSPI_MSB];
         if (!test_n_s) begin
            o_so_oe_n <= 1'h0;
         end else if (so_dis_q) begin
            o_so_oe_n <= 1'h1;
         end else begin
            o_so_oe_n <= cs_s;
         end
      end
   end

   // ------------------------------------------------------------
   // Integrate and hold
   // ------------------------------------------------------------
   // mode and sample-hold
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_integrate                  <= 1'h0;
         o_integrator_buffered_output <= `KNKSPI_RST_WORD;
      end else begin
         o_integrate <= ih_s;
         if (ih_s) begin
            o_integrator_buffered_output <= i_integrator_level;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence seq_full_word;
      state_q == KNKSPI_FULL;
   endsequence

   sequence seq_release;
      cs_rise;
   endsequence

   AST_CS_IGNORE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      cs_s |=> (cnt_q == `KNKSPI_CNT_ZERO) && (state_q == KNKSPI_IDLE))
      else $error("framing advanced while deselected");

   AST_SO_FLOAT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (cs_s && test_n_s) |=> o_so_oe_n)
      else $error("output driven while deselected");

   AST_SO_DIS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (so_dis_q && test_n_s && !cs_s) |=> o_so_oe_n)
      else $error("disabled output still driven");

   AST_SO_EN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!so_dis_q && test_n_s && !cs_s) |=> !o_so_oe_n)
      else $error("enabled output not driven when selected");

   AST_DIAG: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !test_n_s |=> !o_so_oe_n)
      else $error("diagnostic mode did not drive output");

   AST_EIGHT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      seq_full_word |-> cnt_q == `KNKSPI_WORD_BITS)
      else $error("word complete without eight bits");

   AST_COMMIT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (seq_full_word ##0 seq_release) |=> o_param_word == $past(shift_q))
      else $error("completed word not applied");

   AST_NO_COMMIT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_q != KNKSPI_FULL) |=> $stable(o_param_word))
      else $error("partial word applied");

   AST_CHAN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (commit && word_class == `KNKSPI_CLASS_CHANNEL)
      |=> o_channel == $past(shift_q[`KNKSPI_CTRL_BIT]))
      else $error("channel not switched");

   AST_INT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ih_s |=> o_integrate ##0 o_integrator_buffered_output
               == $past(i_integrator_level))
      else $error("integrate mode not followed");

   AST_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!ih_s) [*2] |=> $stable(o_integrator_buffered_output) && !o_integrate)
      else $error("held output moved");

   AST_SHIFT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (sck_fall && !cs_s) |=> shift_q[0] == $past(si_s))
      else $error("bit not taken on falling edge");

endmodule : knkspi_top

// [rtl/knkspi_map.svh]
`ifndef KNKSPI_MAP_SVH
`define KNKSPI_MAP_SVH

// Word length and bit counter
`define KNKSPI_WORD_BITS      4'h8
`define KNKSPI_CNT_ZERO       4'h0
`define KNKSPI_CNT_ONE        4'h1
`define KNKSPI_MSB            7

// Synchroniser rest levels, standing in for the pad pulls
`define KNKSPI_SYNC_HIGH      2'h3
`define KNKSPI_SYNC_LOW       2'h0

// Word class lives in the two top bits of a received word
`define KNKSPI_CLASS_HI       7
`define KNKSPI_CLASS_LO       6
`define KNKSPI_CLASS_PRESCALE 2'h1
`define KNKSPI_CLASS_CHANNEL  2'h3
`define KNKSPI_CTRL_BIT       0

// Reset values
`define KNKSPI_RST_WORD       8'h00
`define KNKSPI_RST_SO_DIS     1'h0
`define KNKSPI_RST_CHANNEL    1'h0

`endif

// [rtl/knkspi_pkg.sv]
package knkspi_pkg;

   typedef enum logic [3:0] {
      KNKSPI_IDLE  = 4'h1,
      KNKSPI_SHIFT = 4'h2,
      KNKSPI_FULL  = 4'h4,
      KNKSPI_OVER  = 4'h8
   } knkspi_state_e;

   typedef logic [7:0] knkspi_word_t;

endpackage : knkspi_pkg

// [bench/knkspi_master.sv]
`timescale 1ns/10ps
// ------------------------------------------
// Serial master model, idle pins at rest
// ------------------------------------------
module knkspi_master (
   input  wire logic i_mclk,
   output logic      o_cs_n,
   output logic      o_sck,
   output logic      o_si
);
   initial begin
      o_cs_n = 1'h1;
      o_sck  = 1'h0;
      o_si   = 1'h1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : tick
   task automatic sel(input logic v);
      o_cs_n <= ~v;
      tick(6);
   endtask : sel
   // clock idles low, falls mid bit
   // nb is 8 except for the 7- and 9-bit bad frames; the deselected bad frame uses 8
   // SI set 4 mclk before the fall, so it clears the 3 mclk margin
   task automatic frame(input logic [8:0] w, input int nb, input logic s);
      o_cs_n <= ~s;
      tick(4);
      for (int i = nb - 1; i >= 0; i--) begin
         o_sck <= 1'h1;
         o_si  <= w[i];
         tick(4);
         o_sck <= 1'h0;
         tick(4);
      end
      // Released SI goes back to its pull-up level
      o_cs_n <= 1'h1;
      o_si   <= 1'h1;
      tick(8);
   endtask : frame
endmodule : knkspi_master

// [bench/knkspi_top_test.sv]
`timescale 1ns/10ps
module knkspi_top_test;
   import knkspi_pkg::*;
   logic         mclk;
   logic         rst_n;
   logic         cs_n;
   logic         sck;
   logic         si;
   logic         int_hold;
   logic         test_n;
   logic         so;
   logic         so_oe_n;
   logic         channel;
   logic         integ;
   knkspi_word_t level;
   knkspi_word_t buf_out;
   knkspi_word_t param;
   int           err_count;
   int           n_checks;

   initial mclk = 1'h0;
   always #50 mclk = ~mclk;

   knkspi_master master (.i_mclk(mclk), .o_cs_n(cs_n), .o_sck(sck),
                         .o_si(si));
   knkspi_top dut (
      .i_mclk                       (mclk),
      .i_rst_n                      (rst_n),
      .i_cs_n                       (cs_n),
      .i_sck                        (sck),
      .i_si                         (si),
      .i_int_hold                   (int_hold),
      .i_test_n                     (test_n),
      .i_integrator_level           (level),
      .o_so                         (so),
      .o_so_oe_n                    (so_oe_n),
      .o_channel                    (channel),
      .o_integrate                  (integ),
      .o_integrator_buffered_output (buf_out),
      .o_param_word                 (param)
   );

   // ------------------------------------------
   // Checking and closing
   // ------------------------------------------
   // Values are read just before the edge settles, one cycle stale at most
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t ns: got %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   task automatic t_rest;
      chk_bit(so_oe_n, 1'h1);
      chk_bit(channel, 1'h0);
      chk(param, 8'h00);
      chk_bit(integ, 1'h0);
      chk(buf_out, 8'h00);
      $display("test rest done");
   endtask : t_rest
   task automatic t_channel;
      master.frame(9'h0C1, 8, 1'h1);
      chk_bit(channel, 1'h1);
      chk(param, 8'hC1);
      chk_bit(so, 1'h1);
      master.frame(9'h0C0, 8, 1'h1);
      chk_bit(channel, 1'h0);
      $display("test channel done");
   endtask : t_channel
   task automatic t_bad;
      master.frame(9'h0C1, 7, 1'h1);
      chk(param, 8'hC0);
      master.frame(9'h183, 9, 1'h1);
      chk(param, 8'hC0);
      master.frame(9'h0C1, 8, 1'h0);
      chk(param, 8'hC0);
      chk_bit(channel, 1'h0);
      $display("test bad frames done");
   endtask : t_bad
   task automatic t_so;
      master.sel(1'h1);
      chk_bit(so_oe_n, 1'h0);
      master.sel(1'h0);
      chk_bit(so_oe_n, 1'h1);
      master.frame(9'h041, 8, 1'h1);
      master.sel(1'h1);
      chk_bit(so_oe_n, 1'h1);
      chk_bit(so, 1'h0);
      test_n <= 1'h0;
      master.tick(6);
      chk_bit(so_oe_n, 1'h0);
      master.sel(1'h0);
      chk_bit(so_oe_n, 1'h0);
      test_n <= 1'h1;
      master.frame(9'h040, 8, 1'h1);
      master.sel(1'h1);
      chk_bit(so_oe_n, 1'h0);
      master.sel(1'h0);
      $display("test output enable done");
   endtask : t_so
   task automatic t_integ;
      level    <= 8'h5A;
      int_hold <= 1'h1;
      master.tick(6);
      chk_bit(integ, 1'h1);
      level <= 8'h3C;
      master.tick(2);
      chk(buf_out, 8'h3C);
      int_hold <= 1'h0;
      master.tick(6);
      level <= 8'hA5;
      master.tick(4);
      chk_bit(integ, 1'h0);
      chk(buf_out, 8'h3C);
      $display("test integrate hold done");
   endtask : t_integ

   initial begin
      err_count = 0;
      n_checks  = 0;
      rst_n     = 1'h0;
      int_hold  = 1'h0;
      test_n    = 1'h1;
      level     = 8'h00;
      repeat (5) @(posedge mclk);
      rst_n <= 1'h1;
      master.tick(4);
      t_rest();
      t_channel();
      t_bad();
      t_so();
      t_integ();
      print_verdict();
   end
endmodule : knkspi_top_test
